//--- src/uv_oc_fault_limit_regs.sv
`timescale 1ns/1ps
`default_nettype none

module uv_oc_fault_limit_regs
   import uv_oc_limit_pkg::*;
#(
   parameter int unsigned P_DELAY3_CYCLES = DELAY3_CYC,
   parameter int unsigned P_HICCUP_CYCLES = HICCUP_CYC
) (
   input  wire logic        i_clk,
   input  wire logic        i_reset_n,
   input  wire cmd_req_type i_req,
   output var  cmd_rsp_type o_rsp,
   input  wire logic [2:0]  i_stack_number,
   input  wire logic        i_primary,
   input  wire logic        i_exp_half_amp,
   input  wire logic [15:0] i_uv_fault_limit,
   input  wire logic        i_clear_faults,
   input  wire logic        i_nvm_load,
   input  wire logic        i_nvm_retry_bit,
   input  wire logic [3:0]  i_nvm_oc_step,
   input  wire logic        i_uv_cond,
   input  wire logic        i_in_current_limit,
   input  wire logic        i_enable,
   input  wire logic [7:0]  i_valley_qamp,
   output logic             o_output_enable,
   output logic             o_oc_fault,
   output logic [3:0]       o_oc_step,
   output logic             o_invalid_data_flag,
   output logic             o_comm_fault_flag,
   output logic             o_oc_undervolt_flag,
   output logic             o_status_oc_flag,
   output logic             o_smbalert_n,
   output logic             o_nvm_retry_bit,
   output logic [3:0]       o_nvm_oc_step
);

   // pin synchronisers
   logic [2:0] pin_meta_ff;
   logic [2:0] pin_sync_ff;
   wire  [2:0] pin_raw = {i_enable, i_in_current_limit, i_uv_cond};

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         pin_meta_ff <= 3'h0;
         pin_sync_ff <= 3'h0;
      end else begin
         pin_meta_ff <= pin_raw;
         pin_sync_ff <= pin_meta_ff;
      end
   end

   wire uv_now = pin_sync_ff[0];
   wire cl_now = pin_sync_ff[1];
   wire en_now = pin_sync_ff[2];

   // register state
   logic         ignore_n_ff;
   logic [2:0]   retry_ff;
   logic [1:0]   delay_ff;
   logic [7:0]   mant_ff;
   logic [3:0]   step_ff;
   logic         ign_prev_ff;
   logic         uv_rec_ff;
   logic         uvcl_prev_ff;
   uv_state_type state_ff;
   logic [CNT_W-1:0] cnt_ff;
   logic         ivd_ff;
   logic         cml_ff;
   logic         oc_undervolt_flag_ff;
   logic         stoc_ff;
   logic         oc_fault_ff;
   logic         out_en_ff;
   logic         alert_n_ff;
   cmd_rsp_type  rsp_ff;

   // request decode
   wire wr     = i_req.valid & i_req.write;
   wire rd     = i_req.valid & ~i_req.write;
   wire hit_uv = i_req.code == CMD_UV_RESPONSE;
   wire hit_oc = i_req.code == CMD_OC_LIMIT;
   wire hit_lt = i_req.code == CMD_LV_THRESHOLD;
   wire hit_lr = i_req.code == CMD_LV_RESPONSE;

   // undervoltage response write checks
   wire [2:0] w_retry = i_req.wdata[UV_RETRY_HI:UV_RETRY_LO];
   wire       uv_bad_top = i_req.wdata[UV_BIT_UNUSED];
   wire       uv_bad_rs  = (w_retry != RETRY_LATCH)
                         & (w_retry != RETRY_HICCUP);
   wire       uv_bad     = uv_bad_top | uv_bad_rs;
   wire       uv_wr_ok   = wr & hit_uv & ~uv_bad;
   wire       uv_wr_bad  = wr & hit_uv & uv_bad;

   // bit 2 of the delay field is dropped, never stored
   wire [7:0] uv_byte = {1'b0, ignore_n_ff, retry_ff,
                         1'b0, delay_ff};

   // overcurrent limit word
   wire [4:0]  oc_exp = i_exp_half_amp ? OC_EXP_HALF
                                       : OC_EXP_ONE;
   wire [15:0] oc_word = {oc_exp, 3'h0, mant_ff};
   wire        b7_ok = i_stack_number > STACK_TWO;
   wire        b6_ok = i_stack_number > STACK_ONE;
   wire        oc_hi_chg = i_req.wdata[15:8] != oc_word[15:8];
   wire        oc_b7_chg = (i_req.wdata[OC_MANT_HI] != mant_ff[OC_MANT_HI])
                         & ~b7_ok;
   wire        oc_b6_chg = (i_req.wdata[OC_BIT6] != mant_ff[OC_BIT6])
                         & ~b6_ok;
   wire        oc_bad    = oc_hi_chg | oc_b7_chg | oc_b6_chg;
   wire        oc_wr_ok  = wr & hit_oc & ~oc_bad;
   wire        oc_wr_bad = wr & hit_oc & oc_bad;

   // per-phase share of a broadcast stack level
   wire [7:0] w_val  = i_req.wdata[7:0];
   wire [8:0] half_s = (9'(w_val) + 9'h001) >> 1;
   wire [9:0] quar_s = (10'(w_val) + 10'h002) >> 2;
   wire       bc     = i_req.bcast_phase;
   wire [3:0] step_2ph = bin_step(half_s[7:0], 1'b0);
   wire [3:0] step_4ph = bin_step(quar_s[7:0], 1'b0);
   wire [3:0] step_3ph = bin_step(w_val, 1'b1);
   wire [3:0] step_1ph = bin_step(w_val, 1'b0);
   wire [3:0] wr_step =
      (bc && i_stack_number == STACK_TWO)   ? step_2ph :
      (bc && i_stack_number == STACK_FOUR)  ? step_4ph :
      (bc && i_stack_number == STACK_THREE) ? step_3ph : step_1ph;

   // broadcast read product, only the primary answers
   wire [10:0] bc_prod = 11'(mant_ff) * 11'(i_stack_number);
   wire [15:0] bc_word = {oc_exp, bc_prod};

   wire [15:0] rd_data =
      hit_uv ? {8'h00, uv_byte} :
      hit_oc ? (bc ? bc_word : oc_word) :
      hit_lt ? i_uv_fault_limit :
      hit_lr ? {8'h00, uv_byte} : 16'h0000;
   wire rd_known = hit_uv | hit_oc | hit_lt | hit_lr;
   wire rd_nack  = ~rd_known | (hit_oc & bc & ~i_primary);
   wire wr_nack  = uv_wr_bad | oc_wr_bad | ~(hit_uv | hit_oc);

   cmd_rsp_type nxt_rsp;
   assign nxt_rsp.valid = i_req.valid;
   assign nxt_rsp.nack  = i_req.write ? wr_nack : rd_nack;
   assign nxt_rsp.rdata = rd ? rd_data : 16'h0000;

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         rsp_ff <= '0;
      end else begin
         rsp_ff <= nxt_rsp;
      end
   end

   // configuration registers; an NVM restore overrides a same-cycle write
   wire [2:0] nvm_retry = {3{i_nvm_retry_bit}};
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         ignore_n_ff <= RST_IGNORE_N;
         retry_ff    <= RETRY_LATCH;
         delay_ff    <= RST_DELAY_SEL;
      end else if (i_nvm_load) begin
         retry_ff    <= nvm_retry;
      end else if (uv_wr_ok) begin
         ignore_n_ff <= i_req.wdata[UV_BIT_IGNORE];
         retry_ff    <= w_retry;
         delay_ff    <= i_req.wdata[UV_DLY_HI:UV_DLY_LO];
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         mant_ff <= RST_OC_MANT;
         step_ff <= RST_OC_STEP;
      end else if (i_nvm_load) begin
         mant_ff <= restore_code(i_nvm_oc_step);
         step_ff <= i_nvm_oc_step;
      end else if (oc_wr_ok) begin
         mant_ff <= w_val;
         step_ff <= wr_step;
      end
   end

   // undervoltage response sequencer
   wire ign_rise  = ignore_n_ff & ~ign_prev_ff;
   wire stale_act = ign_rise & uv_rec_ff;
   wire [CNT_W-1:0] dly_last =
      (delay_ff == 2'h0) ? CNT_W'(DELAY0_CYC - 1) :
      (delay_ff == 2'h1) ? CNT_W'(DELAY1_CYC - 1) :
      (delay_ff == 2'h2) ? CNT_W'(DELAY2_CYC - 1) :
                           CNT_W'(P_DELAY3_CYCLES - 1);
   wire [CNT_W-1:0] hic_last = CNT_W'(P_HICCUP_CYCLES - 1);
   wire dly_done = cnt_ff == dly_last;
   wire hic_done = cnt_ff == hic_last;
   wire hiccup_sel = retry_ff == RETRY_HICCUP;
   uv_state_type retry_state;
   assign retry_state = hiccup_sel ? ST_HICCUP : ST_LATCHED;

   uv_state_type     nxt_state;
   logic [CNT_W-1:0] nxt_cnt;

   always_comb begin
      nxt_state = state_ff;
      nxt_cnt   = '0;
      unique case (state_ff)
         ST_RUN: begin
            if (stale_act) begin
               nxt_state = retry_state;
            end else if (uv_now && ignore_n_ff && en_now) begin
               nxt_state = ST_DELAY;
            end
         end
         ST_DELAY: begin
            if (!uv_now || !ignore_n_ff) begin
               nxt_state = ST_RUN;
            end else if (dly_done) begin
               nxt_state = retry_state;
            end else begin
               nxt_cnt = cnt_ff + 1'b1;
            end
         end
         ST_LATCHED: begin
            // only an enable toggle releases the latch
            if (!en_now) begin
               nxt_state = ST_RUN;
            end
         end
         ST_HICCUP: begin
            if (!en_now || hic_done) begin
               nxt_state = ST_RUN;
            end else begin
               nxt_cnt = cnt_ff + 1'b1;
            end
         end
      endcase
   end

   // ignored faults are remembered until cleared or consumed
   wire uv_ignored = uv_now & ~ignore_n_ff;
   wire nxt_rec = uv_ignored | (uv_rec_ff & ~i_clear_faults & ~stale_act);

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         state_ff    <= ST_RUN;
         cnt_ff      <= '0;
         ign_prev_ff <= RST_IGNORE_N;
         uv_rec_ff   <= 1'b0;
      end else begin
         state_ff    <= nxt_state;
         cnt_ff      <= nxt_cnt;
         ign_prev_ff <= ignore_n_ff;
         uv_rec_ff   <= nxt_rec;
      end
   end

   // delay phase keeps the output on; a remembered ignored fault turns it off once ignoring ends
   wire nxt_out_en = en_now & ((nxt_state == ST_RUN)
                             | (nxt_state == ST_DELAY));

   // sticky flags; a set in the clearing cycle wins
   wire uvcl      = uv_now & cl_now;
   wire oc_undervolt_flag_evt  = uvcl & ~uvcl_prev_ff;
   wire ivd_evt   = uv_wr_bad | oc_wr_bad;
   wire nxt_ivd   = ivd_evt | (ivd_ff & ~i_clear_faults);
   wire nxt_cml   = oc_wr_bad | (cml_ff & ~i_clear_faults);
   wire nxt_oc_undervolt_flag  = oc_undervolt_flag_evt | (oc_undervolt_flag_ff & ~i_clear_faults);
   wire nxt_stoc  = oc_undervolt_flag_evt | (stoc_ff & ~i_clear_faults);
   wire nxt_alert_n = ~(nxt_ivd | nxt_cml | nxt_oc_undervolt_flag | nxt_stoc);
   wire nxt_oc_fault = i_valley_qamp >= STEP_QAMP[step_ff];

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         ivd_ff       <= 1'b0;
         cml_ff       <= 1'b0;
         oc_undervolt_flag_ff      <= 1'b0;
         stoc_ff      <= 1'b0;
         alert_n_ff   <= 1'b1;
         uvcl_prev_ff <= 1'b0;
         oc_fault_ff  <= 1'b0;
         out_en_ff    <= 1'b0;
      end else begin
         ivd_ff       <= nxt_ivd;
         cml_ff       <= nxt_cml;
         oc_undervolt_flag_ff      <= nxt_oc_undervolt_flag;
         stoc_ff      <= nxt_stoc;
         alert_n_ff   <= nxt_alert_n;
         uvcl_prev_ff <= uvcl;
         oc_fault_ff  <= nxt_oc_fault;
         out_en_ff    <= nxt_out_en;
      end
   end

   assign o_rsp               = rsp_ff;
   assign o_output_enable     = out_en_ff;
   assign o_oc_fault          = oc_fault_ff;
   assign o_oc_step           = step_ff;
   assign o_invalid_data_flag = ivd_ff;
   assign o_comm_fault_flag   = cml_ff;
   assign o_oc_undervolt_flag = oc_undervolt_flag_ff;
   assign o_status_oc_flag    = stoc_ff;
   assign o_smbalert_n        = alert_n_ff;
   assign o_nvm_retry_bit     = retry_ff[UV_RETRY_HI - UV_RETRY_LO];
   assign o_nvm_oc_step       = step_ff;

endmodule : uv_oc_fault_limit_regs

`default_nettype wire

//--- src/uv_oc_limit_pkg.sv
package uv_oc_limit_pkg;

   // command codes
   localparam logic [7:0] CMD_UV_RESPONSE  = 8'h45;
   localparam logic [7:0] CMD_OC_LIMIT     = 8'h46;
   localparam logic [7:0] CMD_LV_THRESHOLD = 8'h48;
   localparam logic [7:0] CMD_LV_RESPONSE  = 8'h49;

   // undervoltage response byte layout
   localparam int UV_BIT_UNUSED = 7;
   localparam int UV_BIT_IGNORE = 6;
   localparam int UV_RETRY_HI   = 5;
   localparam int UV_RETRY_LO   = 3;
   localparam int UV_BIT_DLY2   = 2;
   localparam int UV_DLY_HI     = 1;
   localparam int UV_DLY_LO     = 0;

   // reset values and retry encodings
   localparam logic       RST_IGNORE_N  = 1'b1;
   localparam logic [2:0] RETRY_LATCH   = 3'h0;
   localparam logic [2:0] RETRY_HICCUP  = 3'h7;
   localparam logic [1:0] RST_DELAY_SEL = 2'h0;
   localparam logic [7:0] RST_OC_MANT   = 8'h00;
   localparam logic [3:0] RST_OC_STEP   = 4'h0;

   // overcurrent limit word layout
   localparam int         OC_EXP_LO   = 11;
   localparam int         OC_MANT_HI  = 7;
   localparam int         OC_BIT6     = 6;
   localparam logic [4:0] OC_EXP_HALF = 5'h1F;
   localparam logic [4:0] OC_EXP_ONE  = 5'h00;

   // stack sizes
   localparam logic [2:0] STACK_ONE   = 3'h1;
   localparam logic [2:0] STACK_TWO   = 3'h2;
   localparam logic [2:0] STACK_THREE = 3'h3;
   localparam logic [2:0] STACK_FOUR  = 3'h4;

   // timing
   localparam int CLK_PERIOD_NS = 25;
   localparam int DELAY0_NS     = 2000;
   localparam int DELAY1_NS     = 16000;
   localparam int DELAY2_NS     = 64000;
   localparam int DELAY3_NS     = 256000;
   localparam int HICCUP_MS     = 52;
   localparam int DELAY0_CYC = (DELAY0_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DELAY1_CYC = (DELAY1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DELAY2_CYC = (DELAY2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DELAY3_CYC = (DELAY3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int HICCUP_CYC = (HICCUP_MS * 1000000) / CLK_PERIOD_NS;
   localparam int CNT_W      = 22;

   // bin lower bounds for steps 1..13, single phase and 3-phase stack
   localparam int NUM_BOUNDS = 13;
   localparam logic [7:0] BIN_1PH [0:12] = '{8'h0E, 8'h11, 8'h16, 8'h19,
      8'h1C, 8'h21, 8'h25, 8'h27, 8'h2A, 8'h2F, 8'h32, 8'h35, 8'h3A};
   localparam logic [7:0] BIN_3PH [0:12] = '{8'h2A, 8'h33, 8'h40, 8'h4B,
      8'h55, 8'h62, 8'h6D, 8'h75, 8'h7E, 8'h8B, 8'h94, 8'h9E, 8'hAD};
   // valley thresholds per step in quarter amperes (12.5 A .. 60 A)
   localparam logic [7:0] STEP_QAMP [0:13] = '{8'h32, 8'h3C, 8'h4B, 8'h5F,
      8'h69, 8'h78, 8'h8C, 8'h96, 8'hA0, 8'hAF, 8'hC3, 8'hC8, 8'hDC, 8'hF0};
   localparam logic [7:0] RESTORE_STEP0 = 8'h0C;

   typedef enum logic [1:0] {
      ST_RUN     = 2'b00,
      ST_DELAY   = 2'b01,
      ST_LATCHED = 2'b10,
      ST_HICCUP  = 2'b11
   } uv_state_type;

   typedef struct packed {
      logic        valid;
      logic        write;
      logic        bcast_phase;
      logic [7:0]  code;
      logic [15:0] wdata;
   } cmd_req_type;

   typedef struct packed {
      logic        valid;
      logic        nack;
      logic [15:0] rdata;
   } cmd_rsp_type;

   function automatic logic [3:0] bin_step(input logic [7:0] v,
                                           input logic       three_ph);
      logic [3:0] s;
      s = 4'h0;
      for (int k = 0; k < NUM_BOUNDS; k++) begin
         if (v >= (three_ph ? BIN_3PH[k] : BIN_1PH[k])) begin
            s = 4'(k + 1);
         end
      end
      return s;
   endfunction : bin_step

   function automatic logic [7:0] restore_code(input logic [3:0] step);
      logic [7:0] c;
      c = RESTORE_STEP0;
      for (int k = 0; k < NUM_BOUNDS; k++) begin
         if (step == 4'(k + 1)) begin
            c = BIN_1PH[k];
         end
      end
      return c;
   endfunction : restore_code

endpackage : uv_oc_limit_pkg

//--- verif/uv_oc_fault_limit_regs_checker.sv
`timescale 1ns/1ps
`default_nettype none

module uv_oc_fault_limit_regs_checker
   import uv_oc_limit_pkg::*;
(
   input wire logic        i_clk,
   input wire logic        i_reset_n,
   input wire cmd_req_type i_req,
   input wire cmd_rsp_type o_rsp,
   input wire logic [2:0]  i_stack_number,
   input wire logic        i_primary,
   input wire logic        i_exp_half_amp,
   input wire logic [15:0] i_uv_fault_limit,
   input wire logic        o_invalid_data_flag,
   input wire logic        o_comm_fault_flag,
   input wire logic        o_oc_undervolt_flag,
   input wire logic        o_smbalert_n
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);

   wire logic       wr_req  = i_req.valid & i_req.write;
   wire logic       rd_req  = i_req.valid & ~i_req.write;
   wire logic [4:0] exp_now = i_exp_half_amp ? OC_EXP_HALF : OC_EXP_ONE;

   a_resp_bit7_nack: assert property (
      wr_req && i_req.code == CMD_UV_RESPONSE && i_req.wdata[7]
      |=> o_rsp.nack && o_invalid_data_flag) else $error("bit 7 not refused");
   a_retry_code_nack: assert property (
      wr_req && i_req.code == CMD_UV_RESPONSE && i_req.wdata[5:3] != 3'h0
      && i_req.wdata[5:3] != 3'h7 |=> o_rsp.nack && o_invalid_data_flag)
      else $error("mixed retry code not refused");
   a_resp_reads_zero: assert property (
      rd_req && i_req.code == CMD_UV_RESPONSE
      |=> o_rsp.valid && o_rsp.rdata[15:7] == 9'h000 && !o_rsp.rdata[2])
      else $error("response byte fixed bits not zero");
   a_oc_upper_nack: assert property (
      wr_req && i_req.code == CMD_OC_LIMIT && i_stack_number == STACK_ONE
      && i_req.wdata[15:8] != {exp_now, 3'h0}
      |=> o_rsp.nack && o_comm_fault_flag && o_invalid_data_flag)
      else $error("upper limit bits change not refused");
   a_oc_bit_stack: assert property (
      wr_req && i_req.code == CMD_OC_LIMIT
      && (i_req.wdata[7] && i_stack_number <= STACK_TWO
      || i_req.wdata[6] && i_stack_number <= STACK_ONE) |=> o_rsp.nack)
      else $error("stack gated limit bit accepted");
   a_oc_exp_auto: assert property (
      rd_req && i_req.code == CMD_OC_LIMIT && !i_req.bcast_phase
      |=> o_rsp.rdata[15:11] == $past(exp_now) && o_rsp.rdata[10:8] == 3'h0)
      else $error("limit exponent wrong");
   a_lv_thr_mirror: assert property (
      rd_req && i_req.code == CMD_LV_THRESHOLD
      |=> !o_rsp.nack && o_rsp.rdata == $past(i_uv_fault_limit))
      else $error("threshold copy differs");
   a_lv_write_nack: assert property (
      wr_req && (i_req.code == CMD_LV_THRESHOLD
      || i_req.code == CMD_LV_RESPONSE) |=> o_rsp.valid && o_rsp.nack)
      else $error("read-only mirror accepted a write");
   a_bcast_rd_sec: assert property (
      rd_req && i_req.code == CMD_OC_LIMIT && i_req.bcast_phase && !i_primary
      |=> o_rsp.nack) else $error("secondary answered broadcast read");
   a_oc_undervolt_flag_alert: assert property (
      $rose(o_oc_undervolt_flag) |-> ##[0:1] !o_smbalert_n)
      else $error("alert missing after flag");
endmodule : uv_oc_fault_limit_regs_checker

`default_nettype wire

//--- verif/pmbus_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module pmbus_host_model
   import uv_oc_limit_pkg::*;
(
   input  wire logic        i_clk,
   output var cmd_req_type  o_req,
   input  wire cmd_rsp_type i_rsp
);
   initial o_req = '0;

   task automatic xfer(input logic w, input logic b, input logic [7:0] c,
                       input logic [15:0] d, output logic v,
                       output logic nk, output logic [15:0] rd);
      @(posedge i_clk);
      #1;
      o_req = '{valid: 1'b1, write: w, bcast_phase: b, code: c, wdata: d};
      @(posedge i_clk);
      #1;
      v  = i_rsp.valid;
      nk = i_rsp.nack;
      rd = i_rsp.rdata;
      // idle fields flipped so a stale qualifier is never trusted
      o_req = '{1'b0, ~w, ~b, ~c, ~d};
   endtask : xfer
endmodule : pmbus_host_model

`default_nettype wire

//--- verif/uv_oc_fault_limit_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none

module uv_oc_fault_limit_regs_tb;
   import uv_oc_limit_pkg::*;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   cmd_req_type req;
   cmd_rsp_type rsp;
   logic [2:0]  stack = STACK_ONE;
   logic        prim = 1'b1;
   logic        clr = 1'b0;
   logic        ld = 1'b0;
   logic        uv = 1'b0;
   logic        ilim = 1'b0;
   logic        en = 1'b1;
   logic [7:0]  valley = 8'h00;
   logic        exph = 1'b1;
   logic [15:0] uvlim = 16'h0123;
   logic        oe, ocf, ivd, cml, oc_undervolt_flag, soc, alert_n, nrb;
   logic [3:0]  step, nst, e;
   int          fail_count = 0;
   int          tests_run = 0;
   int          b1[13] = '{14, 17, 22, 25, 28, 33, 37, 39, 42, 47, 50, 53, 58};
   int          b3[13] = '{42, 51, 64, 75, 85, 98, 109, 117, 126, 139, 148,
                           158, 173};
   int          m1[6] = '{13, 14, 57, 58, 33, 63};
   int          bst[6] = '{2, 2, 4, 4, 3, 3};
   int          bv[6] = '{79, 40, 229, 230, 173, 41};

   always #12.5 clk = ~clk;

   pmbus_host_model u_host (.i_clk(clk), .o_req(req), .i_rsp(rsp));

   // short delay and hiccup counts keep the run small
   uv_oc_fault_limit_regs #(.P_DELAY3_CYCLES(40), .P_HICCUP_CYCLES(100)) u_dut (
      .i_clk(clk), .i_reset_n(rst_n), .i_req(req), .o_rsp(rsp),
      .i_stack_number(stack), .i_primary(prim), .i_exp_half_amp(exph),
      .i_uv_fault_limit(uvlim), .i_clear_faults(clr), .i_nvm_load(ld),
      .i_nvm_retry_bit(1'b1), .i_nvm_oc_step(4'h3), .i_uv_cond(uv),
      .i_in_current_limit(ilim), .i_enable(en), .i_valley_qamp(valley),
      .o_output_enable(oe), .o_oc_fault(ocf), .o_oc_step(step),
      .o_invalid_data_flag(ivd), .o_comm_fault_flag(cml),
      .o_oc_undervolt_flag(oc_undervolt_flag), .o_status_oc_flag(soc),
      .o_smbalert_n(alert_n), .o_nvm_retry_bit(nrb), .o_nvm_oc_step(nst));

   function automatic logic [3:0] bin(input int v, input int b[13]);
      bin = 4'h0;
      for (int k = 0; k < 13; k++) if (v >= b[k]) bin = 4'(k + 1);
   endfunction : bin

   function automatic logic [15:0] ow(input logic [7:0] m);
      return {OC_EXP_HALF, 3'h0, m};
   endfunction : ow

   task automatic finish_test;
      if (fail_count == 0 && tests_run > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : finish_test

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc

   task automatic chk(input logic [15:0] g, input logic [15:0] x);
      tests_run++;
      if (g !== x) begin
         fail_count++;
         $display("[FAIL] %0t word %h expected %h", $time, g, x);
      end
   endtask : chk

   task automatic chkf(input logic [4:0] g, input logic [4:0] x);
      tests_run++;
      if (g !== x) begin
         fail_count++;
         $display("[FAIL] %0t flags %b expected %b", $time, g, x);
      end
   endtask : chkf

   task automatic wr(input logic [7:0] c, input logic b, input logic [15:0] d,
                     input logic enk);
      logic        v, nk;
      logic [15:0] r;
      u_host.xfer(1'b1, b, c, d, v, nk, r);
      chkf(5'({v, nk}), 5'({1'b1, enk}));
   endtask : wr

   task automatic rd(input logic [7:0] c, input logic b, input logic enk,
                     input logic [15:0] x);
      logic        v, nk;
      logic [15:0] r;
      u_host.xfer(1'b0, b, c, 16'h0000, v, nk, r);
      chkf(5'({v, nk}), 5'({1'b1, enk}));
      if (!enk) chk(r, x);
   endtask : rd

   task automatic clear_flags;
      clr = 1'b1;
      cyc(1);
      clr = 1'b0;
      cyc(1);
   endtask : clear_flags

   task automatic hold_oe(input logic v, input int n);
      repeat (n) begin
         cyc(1);
         chkf(5'(oe), 5'(v));
      end
   endtask : hold_oe

   task automatic wait_oe(input logic v, input int n);
      for (int i = 0; i < n && oe !== v; i++) cyc(1);
      chkf(5'(oe), 5'(v));
      if (oe !== v) finish_test;
   endtask : wait_oe

   initial begin
      cyc(16);
      rst_n = 1'b1;
      ld = 1'b1;
      cyc(1);
      ld = 1'b0;
      rd(CMD_UV_RESPONSE, 1'b0, 1'b0, 16'h0078);
      rd(CMD_LV_RESPONSE, 1'b0, 1'b0, 16'h0078);
      rd(CMD_OC_LIMIT, 1'b0, 1'b0, ow(8'h16));
      chkf({nrb, nst}, 5'h13);
      chkf({1'b0, step}, 5'h03);
      rd(CMD_LV_THRESHOLD, 1'b0, 1'b0, 16'h0123);
      uvlim = 16'h03A5;
      rd(CMD_LV_THRESHOLD, 1'b0, 1'b0, 16'h03A5);
      wr(CMD_LV_THRESHOLD, 1'b0, 16'h0000, 1'b1);
      wr(CMD_LV_RESPONSE, 1'b0, 16'h0000, 1'b1);
      rd(8'h47, 1'b0, 1'b1, 16'h0000);
      wr(CMD_UV_RESPONSE, 1'b0, 16'h00F8, 1'b1);
      chkf(5'({ivd, alert_n}), 5'h02);
      for (int r = 1; r < 7; r++) begin
         wr(CMD_UV_RESPONSE, 1'b0, 16'h0040 | 16'(r << 3), 1'b1);
      end
      wr(CMD_UV_RESPONSE, 1'b0, 16'h007C, 1'b0);
      rd(CMD_UV_RESPONSE, 1'b0, 1'b0, 16'h0078);
      clear_flags;
      chkf(5'({ivd, cml, alert_n}), 5'h01);
      wr(CMD_OC_LIMIT, 1'b0, 16'h0000, 1'b1);
      chkf(5'({ivd, cml}), 5'h03);
      wr(CMD_OC_LIMIT, 1'b0, ow(8'h80), 1'b1);
      wr(CMD_OC_LIMIT, 1'b0, ow(8'h40), 1'b1);
      for (int i = 0; i < 6; i++) begin
         wr(CMD_OC_LIMIT, 1'b0, ow(8'(m1[i])), 1'b0);
         rd(CMD_OC_LIMIT, 1'b0, 1'b0, ow(8'(m1[i])));
         chkf(5'(step), 5'(bin(m1[i], b1)));
      end
      for (int i = 0; i < 6; i++) begin
         stack = 3'(bst[i]);
         wr(CMD_OC_LIMIT, 1'b1, ow(8'(bv[i])), 1'b0);
         cyc(2);
         e = bst[i] == 2 ? bin((bv[i] + 1) >> 1, b1)
           : bst[i] == 4 ? bin((bv[i] + 2) >> 2, b1) : bin(bv[i], b3);
         chkf(5'(step), 5'(e));
      end
      wr(CMD_OC_LIMIT, 1'b0, ow(8'h21), 1'b0);
      rd(CMD_OC_LIMIT, 1'b1, 1'b0, {OC_EXP_HALF, 11'h063});
      prim = 1'b0;
      rd(CMD_OC_LIMIT, 1'b1, 1'b1, 16'h0000);
      exph = 1'b0;
      rd(CMD_OC_LIMIT, 1'b0, 1'b0, {OC_EXP_ONE, 3'h0, 8'h21});
      exph = 1'b1;
      rd(CMD_OC_LIMIT, 1'b0, 1'b0, ow(8'h21));
      // step 6 trips at 35 A, in quarter amperes
      valley = 8'h8B;
      cyc(4);
      chkf(5'(ocf), 5'h00);
      valley = 8'h8C;
      cyc(4);
      chkf(5'(ocf), 5'h01);
      clear_flags;
      wr(CMD_UV_RESPONSE, 1'b0, 16'h0078, 1'b0);
      wait_oe(1'b1, 10);
      uv = 1'b1;
      hold_oe(1'b1, 40);
      uv = 1'b0;
      hold_oe(1'b1, 5);
      uv = 1'b1;
      hold_oe(1'b1, 75);
      wait_oe(1'b0, 15);
      uv = 1'b0;
      hold_oe(1'b0, 90);
      wait_oe(1'b1, 20);
      // delay code 1 must hold the output on for the whole delay
      wr(CMD_UV_RESPONSE, 1'b0, 16'h0079, 1'b0);
      uv = 1'b1;
      hold_oe(1'b1, DELAY1_CYC);
      wait_oe(1'b0, 10);
      uv = 1'b0;
      wait_oe(1'b1, 120);
      wr(CMD_UV_RESPONSE, 1'b0, 16'h0040, 1'b0);
      uv = 1'b1;
      wait_oe(1'b0, 100);
      uv = 1'b0;
      hold_oe(1'b0, 150);
      en = 1'b0;
      cyc(5);
      en = 1'b1;
      wait_oe(1'b1, 10);
      wr(CMD_UV_RESPONSE, 1'b0, 16'h0000, 1'b0);
      uv = 1'b1;
      hold_oe(1'b1, 120);
      uv = 1'b0;
      cyc(5);
      wr(CMD_UV_RESPONSE, 1'b0, 16'h0040, 1'b0);
      wait_oe(1'b0, 100);
      ilim = 1'b1;
      uv = 1'b1;
      cyc(4);
      chkf(5'({oc_undervolt_flag, soc, alert_n}), 5'h06);
      finish_test;
   end
endmodule : uv_oc_fault_limit_regs_tb

bind uv_oc_fault_limit_regs uv_oc_fault_limit_regs_checker u_chk (
   .i_clk(i_clk), .i_reset_n(i_reset_n), .i_req(i_req), .o_rsp(o_rsp),
   .i_stack_number(i_stack_number), .i_primary(i_primary),
   .i_exp_half_amp(i_exp_half_amp), .i_uv_fault_limit(i_uv_fault_limit),
   .o_invalid_data_flag(o_invalid_data_flag),
   .o_comm_fault_flag(o_comm_fault_flag),
   .o_oc_undervolt_flag(o_oc_undervolt_flag), .o_smbalert_n(o_smbalert_n));

`default_nettype wire
